// file: hw/rop_pkg.sv
// shared constants for the conversion result readout port
package rop_pkg;
    localparam int RES_W = 16;
    localparam int CLK_PERIOD_NS = 10;
    // one successive-approximation bit decision, and the extra time of late bits
    localparam int SAR_STEP_NS = 30;
    localparam int SAR_STEP_CYC =
        (SAR_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SAR_LSB_EXTRA_NS = 20;
    localparam int SAR_LSB_EXTRA_CYC =
        (SAR_LSB_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [4:0] SAR_SLOW_FROM_BIT = 5'h0C;
    // half period of the generated clock before division
    localparam int MSCLK_HALF_NS = 20;
    localparam int MSCLK_HALF_CYC =
        (MSCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 8;
    localparam logic [4:0] LAST_BIT = 5'h0F;
    localparam logic [4:0] ALL_BITS = 5'h10;
    localparam logic [RES_W-1:0] RESULT_RST = 16'h0000;
endpackage

// file: hw/rop_shift_if.sv
// carrier between the readout control and the result shifter
`timescale 1ns/1ps
interface rop_shift_if;
    logic load;
    logic [15:0] load_word;
    logic shift;
    logic capture;
    logic chain_bit;
    logic msb;
    modport ctrl
    (
        output load, load_word, shift, capture, chain_bit,
        input msb
    );
    modport shifter
    (
        input load, load_word, shift, capture, chain_bit,
        output msb
    );
endinterface

// file: hw/rop_shifter.sv
// result shift register with chained serial input
`timescale 1ns/1ps
module rop_shifter
    import rop_pkg::*;
#(
    parameter int W = 16
)
(
    input wire logic core_clk_in, // core clock
    input wire logic rst_n_in, // async reset, active low
    rop_shift_if.shifter sh // load, shift and chain controls
);
    typedef struct packed
    {
        logic [W-1:0] sr;
        logic pend;
    } rop_shifter_s;

    rop_shifter_s s_r;
    rop_shifter_s s_nxt;

    always_comb
    begin
        s_nxt = s_r;
        // chain bit is caught on the opposite edge, used on the next shift
        if (sh.capture)
        begin
            s_nxt.pend = sh.chain_bit;
        end
        if (sh.load)
        begin
            s_nxt.sr = sh.load_word;
            s_nxt.pend = 1'b0;
        end
        else if (sh.shift)
        begin
            s_nxt.sr = {s_r.sr[W-2:0], s_r.pend};
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign sh.msb = s_r.sr[W-1];
endmodule

// file: hw/rop_readout.sv
// conversion timing and result readout over parallel or serial port
`timescale 1ns/1ps
module rop_readout
    import rop_pkg::*;
(
    input wire logic core_clk_in, // core clock, 100 MHz
    input wire logic rst_n_in, // async reset, active low
    input wire logic convert_start_n_in, // falling edge starts conversion
    input wire logic cs_n_in, // chip select, active low
    input wire logic rd_n_in, // read enable, active low
    input wire logic serial_parallel_select_in, // high: serial port
    input wire logic byte_order_select_in, // high: bytes swapped
    input wire logic clock_source_select_in, // high: host clock
    input wire logic read_during_convert_or_chain_in_in, // mode or chain
    input wire logic [1:0] clock_divider_select_in, // slows master clock in the read-after-conversion transfer
    input wire logic serial_invert_in, // inverts clock and sync out
    input wire logic ext_sclk_in, // host serial clock, sampled
    input wire logic [RES_W-1:0] sar_result_in, // coded result at end
    output logic busy_out, // conversion or master transfer running
    output logic [RES_W-1:0] data_out, // parallel data lines
    output logic data_oe_n_out, // low while data lines driven
    output logic serial_data_out_out, // serial result bit
    output logic serial_oe_n_out, // low while serial data driven
    output logic sclk_out, // generated serial clock
    output logic sclk_oe_n_out, // low while serial clock driven
    output logic sync_out, // serial data valid strobe
    output logic read_overrun_flag_out // one-cycle overrun pulse
);
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b001,
        ST_CONV = 3'b010,
        ST_XFER = 3'b100
    } rop_state_e;

    typedef struct packed
    {
        rop_state_e st;
        logic convert_start_n_d;
        logic sclk_d;
        logic sclk_ok;
        logic [4:0] bit_cnt;
        logic [CNT_W-1:0] tick;
        logic busy;
        logic [RES_W-1:0] result;
        logic [RES_W-1:0] dout;
        logic dout_oe_n;
        logic serial_data_out;
        logic ser_oe_n;
        logic msclk;
        logic msync;
        logic sclk;
        logic sclk_oe_n;
        logic sync;
        logic rderr;
        logic [4:0] rd_cnt;
        logic rd_in_busy;
    } rop_readout_s;

    localparam rop_readout_s STATE_RST = '{
        st: ST_IDLE,
        convert_start_n_d: 1'b1,
        result: RESULT_RST,
        dout_oe_n: 1'b1,
        ser_oe_n: 1'b1,
        sclk_oe_n: 1'b1,
        default: '0
    };

    rop_readout_s s_r;
    rop_readout_s s_nxt;
    rop_shift_if sh();

    logic convert_start_n_fall;
    logic master;
    logic rdc;
    logic ser;
    logic gate;
    logic s_rise;
    logic s_fall;
    logic idle_out;
    logic [CNT_W-1:0] step_len;
    logic [CNT_W-1:0] m_half;

    rop_shifter #(
        .W(RES_W)
    ) u_shifter (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .sh(sh)
    );

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.rderr = 1'b0;
        sh.load = 1'b0;
        sh.load_word = sar_result_in;
        sh.shift = 1'b0;
        sh.capture = 1'b0;
        sh.chain_bit = 1'b0;
        master = ~clock_source_select_in;
        rdc = read_during_convert_or_chain_in_in;
        ser = serial_parallel_select_in;
        convert_start_n_fall = s_r.convert_start_n_d & ~convert_start_n_in;
        s_nxt.convert_start_n_d = convert_start_n_in;
        // host clock only counts while selected and read enabled
        gate = ~cs_n_in & ~rd_n_in & ser & ~master;
        // edge detection on the sampled clock works for any idle level
        // no edge until the pin has been sampled once after reset
        s_rise = gate & s_r.sclk_ok & ~s_r.sclk_d & ext_sclk_in;
        s_fall = gate & s_r.sclk_ok & s_r.sclk_d & ~ext_sclk_in;
        s_nxt.sclk_d = ext_sclk_in;
        s_nxt.sclk_ok = 1'b1;
        // late decisions settle longer, which stretches the paced clock
        step_len = CNT_W'(SAR_STEP_CYC);
        if (s_r.bit_cnt >= SAR_SLOW_FROM_BIT)
        begin
            step_len = CNT_W'(SAR_STEP_CYC + SAR_LSB_EXTRA_CYC);
        end
        m_half = CNT_W'(MSCLK_HALF_CYC) << clock_divider_select_in;

        // slave shifting; reads begun during busy lose the chain input
        if (s_rise)
        begin
            sh.shift = 1'b1;
            if (s_r.rd_cnt != ALL_BITS)
            begin
                s_nxt.rd_cnt = s_r.rd_cnt + 5'h01;
            end
            if (s_r.rd_cnt == 5'h00 && s_r.busy)
            begin
                s_nxt.rd_in_busy = 1'b1;
            end
        end
        if (s_fall)
        begin
            sh.capture = 1'b1;
        end
        if (~master && ~s_r.rd_in_busy)
        begin
            sh.chain_bit = read_during_convert_or_chain_in_in;
        end

        case (s_r.st)
            ST_IDLE:
            begin
                if (convert_start_n_fall)
                begin
                    s_nxt.st = ST_CONV;
                    s_nxt.busy = 1'b1;
                    s_nxt.bit_cnt = 5'h00;
                    s_nxt.tick = '0;
                    s_nxt.msync = master & rdc & ser;
                    if (master && rdc && ser)
                    begin
                        // an earlier read may have drained the shifter
                        sh.load_word = s_r.result;
                        sh.load = 1'b1;
                    end
                end
            end
            ST_CONV:
            begin
                s_nxt.tick = s_r.tick + CNT_W'(1);
                if (master && rdc && ser
                    && s_r.tick == (step_len >> 1) - CNT_W'(1))
                begin
                    s_nxt.msclk = 1'b1;
                end
                if (s_r.tick == step_len - CNT_W'(1))
                begin
                    s_nxt.tick = '0;
                    s_nxt.bit_cnt = s_r.bit_cnt + 5'h01;
                    if (master && rdc && ser)
                    begin
                        s_nxt.msclk = 1'b0;
                        sh.shift = 1'b1;
                    end
                    if (s_r.bit_cnt == LAST_BIT)
                    begin
                        // same coded word feeds both paths
                        s_nxt.result = sar_result_in;
                        sh.load = 1'b1;
                        s_nxt.rd_cnt = 5'h00;
                        s_nxt.rd_in_busy = 1'b0;
                        s_nxt.msync = 1'b0;
                        if (~master && ser && s_r.rd_in_busy
                            && s_r.rd_cnt != ALL_BITS)
                        begin
                            s_nxt.rderr = 1'b1;
                        end
                        if (master && ~rdc && ser)
                        begin
                            // busy covers the whole shift-out
                            s_nxt.st = ST_XFER;
                            s_nxt.bit_cnt = 5'h00;
                            s_nxt.msync = 1'b1;
                        end
                        else
                        begin
                            s_nxt.st = ST_IDLE;
                            s_nxt.busy = 1'b0;
                        end
                    end
                end
            end
            ST_XFER:
            begin
                s_nxt.tick = s_r.tick + CNT_W'(1);
                if (s_r.tick >= m_half - CNT_W'(1))
                begin
                    s_nxt.tick = '0;
                    s_nxt.msclk = ~s_r.msclk;
                    if (s_r.msclk)
                    begin
                        sh.shift = 1'b1;
                        s_nxt.bit_cnt = s_r.bit_cnt + 5'h01;
                        if (s_r.bit_cnt == LAST_BIT)
                        begin
                            s_nxt.st = ST_IDLE;
                            s_nxt.busy = 1'b0;
                            s_nxt.msync = 1'b0;
                        end
                    end
                end
            end
            default:
            begin
                s_nxt = STATE_RST;
            end
        endcase

        // output stage, one flop deep
        idle_out = cs_n_in | rd_n_in;
        if (byte_order_select_in)
        begin
            s_nxt.dout = {s_r.result[7:0], s_r.result[15:8]};
        end
        else
        begin
            s_nxt.dout = s_r.result;
        end
        s_nxt.dout_oe_n = idle_out | ser;
        s_nxt.ser_oe_n = idle_out | ~ser;
        s_nxt.sclk_oe_n = idle_out | ~ser | ~master;
        // bit changes a cycle after shift or load, so it holds across both edges except in 3-cycle paced steps
        s_nxt.serial_data_out = sh.msb;
        s_nxt.sclk = s_nxt.msclk ^ serial_invert_in;
        s_nxt.sync = s_nxt.msync ^ serial_invert_in;
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            s_r <= STATE_RST;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign busy_out = s_r.busy;
    assign data_out = s_r.dout;
    assign data_oe_n_out = s_r.dout_oe_n;
    assign serial_data_out_out = s_r.serial_data_out;
    assign serial_oe_n_out = s_r.ser_oe_n;
    assign sclk_out = s_r.sclk;
    assign sclk_oe_n_out = s_r.sclk_oe_n;
    assign sync_out = s_r.sync;
    assign read_overrun_flag_out = s_r.rderr;
endmodule

// file: verif/rop_checker.sv
// pin-level assertions for the result readout port
`timescale 1ns/1ps
module rop_checker
    import rop_pkg::*;
(
    input wire logic core_clk_in, // clock
    input wire logic rst_n_in, // reset
    input wire logic convert_start_n_in, // pin
    input wire logic cs_n_in, // pin
    input wire logic rd_n_in, // pin
    input wire logic serial_parallel_select_in, // pin
    input wire logic byte_order_select_in, // pin
    input wire logic clock_source_select_in, // pin
    input wire logic read_during_convert_or_chain_in_in, // pin
    input wire logic [1:0] clock_divider_select_in, // pin
    input wire logic serial_invert_in, // pin
    input wire logic ext_sclk_in, // pin
    input wire logic [RES_W-1:0] sar_result_in, // pin
    input wire logic busy_out, // pin
    input wire logic [RES_W-1:0] data_out, // pin
    input wire logic data_oe_n_out, // pin
    input wire logic serial_data_out_out, // pin
    input wire logic serial_oe_n_out, // pin
    input wire logic sclk_out, // pin
    input wire logic sclk_oe_n_out, // pin
    input wire logic sync_out, // pin
    input wire logic read_overrun_flag_out // pin
);
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_n_in);
    logic sel, m_aft, act, tog, sq, iq;
    logic [7:0] bcnt, hcnt, tcnt;
    assign sel = !cs_n_in && !rd_n_in;
    assign m_aft = serial_parallel_select_in && !clock_source_select_in
        && !read_during_convert_or_chain_in_in;
    // sync output lags the invert pin by one flop, so undo it with a copy
    assign act = sync_out ^ iq;
    assign tog = sclk_out != sq;
    // first toggle of a transfer has no previous edge to measure from
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            bcnt <= 8'h00;
            hcnt <= 8'h00;
            tcnt <= 8'h00;
            sq <= 1'b0;
            iq <= 1'b0;
        end
        else
        begin
            bcnt <= busy_out ? bcnt + 8'h01 : 8'h00;
            hcnt <= tog ? 8'h01 : hcnt + 8'h01;
            tcnt <= !act ? 8'h00 : tcnt + {7'h00, tog};
            sq <= sclk_out;
            iq <= serial_invert_in;
        end
    end
    sequence s_start;
        $fell(convert_start_n_in) && !busy_out;
    endsequence
    sequence s_done;
        $fell(busy_out);
    endsequence
    chk_start_busy: assert property (s_start |=> busy_out)
        else $error("busy did not follow convert start");
    chk_conv_len: assert property ((s_done and !m_aft) |-> bcnt == 8'h38)
        else $error("conversion length wrong");
    chk_busy_xfer: assert property (act && m_aft |-> busy_out)
        else $error("busy low during master transfer");
    chk_clk_half: assert property (tog && act && m_aft && tcnt != 8'h00
        |-> hcnt == (8'h02 << clock_divider_select_in))
        else $error("generated clock half period wrong");
    chk_oe_off: assert property (!sel |=> data_oe_n_out
        && serial_oe_n_out && sclk_oe_n_out)
        else $error("output driven while deselected");
    chk_par_oe: assert property (rst_n_in |=> data_oe_n_out ==
        !$past(sel && !serial_parallel_select_in))
        else $error("data enable wrong");
    chk_ser_oe: assert property (1 |=> serial_oe_n_out ==
        !$past(sel && serial_parallel_select_in))
        else $error("serial enable wrong");
    chk_sclk_drv: assert property (1 |=> sclk_oe_n_out == !$past(sel
        && serial_parallel_select_in && !clock_source_select_in))
        else $error("clock enable wrong");
    chk_swap_bytes: assert property ($changed(byte_order_select_in)
        && !busy_out && !$past(busy_out) && !$past(busy_out, 2)
        |=> data_out == {$past(data_out[7:0]), $past(data_out[15:8])})
        else $error("bytes not exchanged");
    chk_overrun_one: assert property (read_overrun_flag_out |->
        (!busy_out && ($past(busy_out) || $past(busy_out, 2)))
        ##1 !read_overrun_flag_out)
        else $error("overrun pulse misplaced");
endmodule

// file: verif/rop_host_model.sv
// host model: captures master serial data, clocks slave reads
`timescale 1ns/1ps
module rop_host_model
(
    input wire logic clk_in, // core clock
    input wire logic sclk_in, // device clock, active high, 0 released
    input wire logic sdo_in, // device serial data
    output logic ext_sclk_out, // host clock, idles high
    output logic chain_out // upstream device bit
);
    logic [31:0] word;
    logic [15:0] up;
    int pulses;
    logic p;
    initial
    begin
        ext_sclk_out = 1'b1;
        chain_out = 1'b0;
        word = 32'h0;
        pulses = 0;
        p = 1'b0;
    end
    always @(posedge clk_in)
    begin
        p <= sclk_in;
        if (!p && sclk_in)
        begin
            word <= {word[30:0], sdo_in};
            pulses <= pulses + 1;
        end
    end
    task clr;
        word <= 32'h0;
        pulses <= 0;
    endtask
    // gapped clock, 6 core cycles a pulse, so well under the rate limit
    task sread(input int n, input logic [15:0] u);
        up = u;
        repeat (n)
        begin
            chain_out <= up[15];
            up = up << 1;
            @(posedge clk_in);
            ext_sclk_out <= 1'b0;
            repeat (3) @(posedge clk_in);
            word <= {word[30:0], sdo_in};
            ext_sclk_out <= 1'b1;
            repeat (2) @(posedge clk_in);
        end
    endtask
endmodule

// file: verif/test_adc_result_readout_port.sv
// self-checking bench for the conversion result readout port
`timescale 1ns/1ps
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin \
    n_fail++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
module test_adc_result_readout_port;
    logic clk, rst_n, cnv_n, cs_n, rd_n, ser, bsw, ext, rdc, inv;
    logic busy, doe_n, sdo, soe_n, sclk, scoe_n, sync, ovf;
    logic [1:0] div;
    logic [15:0] sar, dout, last, v;
    wire esclk, chain;
    int n_fail, cmp_count, nov, i;
    rop_readout dut
    (
        .core_clk_in(clk),
        .rst_n_in(rst_n),
        .convert_start_n_in(cnv_n),
        .cs_n_in(cs_n),
        .rd_n_in(rd_n),
        .serial_parallel_select_in(ser),
        .byte_order_select_in(bsw),
        .clock_source_select_in(ext),
        .read_during_convert_or_chain_in_in(ext ? chain : rdc),
        .clock_divider_select_in(div),
        .serial_invert_in(inv),
        .ext_sclk_in(esclk),
        .sar_result_in(sar),
        .busy_out(busy),
        .data_out(dout),
        .data_oe_n_out(doe_n),
        .serial_data_out_out(sdo),
        .serial_oe_n_out(soe_n),
        .sclk_out(sclk),
        .sclk_oe_n_out(scoe_n),
        .sync_out(sync),
        .read_overrun_flag_out(ovf)
    );
    rop_host_model hm
    (
        .clk_in(clk),
        .sclk_in(!scoe_n && (sclk ^ inv)),
        .sdo_in(sdo),
        .ext_sclk_out(esclk),
        .chain_out(chain)
    );
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
        if (ovf === 1'b1)
            nov <= nov + 1;
    task results;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task conv(input logic [15:0] val);
        int k;
        sar <= val;
        cnv_n <= 1'b0;
        k = 0;
        while (busy !== 1'b1 && k < 8)
        begin
            @(posedge clk);
            k++;
        end
        cnv_n <= 1'b1;
        k = 0;
        while (busy !== 1'b0 && k < 800)
        begin
            @(posedge clk);
            k++;
        end
        `CHK("busy", 1'b0, busy)
        repeat (3) @(posedge clk);
    endtask
    initial
    begin
        repeat (10000) @(posedge clk);
        n_fail++;
        results();
    end
    initial
    begin
        {rst_n, cnv_n, cs_n, rd_n, ser, bsw, ext, rdc, inv} = 9'h080;
        div = 2'h0;
        sar = 16'h0000;
        n_fail = 0;
        cmp_count = 0;
        nov = 0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        conv(16'h12C4);
        `CHK("data", 16'h12C4, dout)
        `CHK("data_oe", 1'b0, doe_n)
        bsw <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK("swap", 16'hC412, dout)
        cs_n <= 1'b1;
        bsw <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK("data_hiz", 1'b1, doe_n)
        `CHK("unswap", 16'h12C4, dout)
        $display("parallel test done");
        ser <= 1'b1;
        cs_n <= 1'b0;
        for (i = 0; i < 4; i++)
        begin
            div <= i[1:0];
            inv <= i[0];
            v = 16'hB2E7 + 16'h1111 * i[15:0];
            repeat (2) @(posedge clk);
            hm.clr();
            conv(v);
            `CHK("master_word", v, hm.word[15:0])
            `CHK("master_bits", 16, hm.pulses)
        end
        last = v;
        $display("master read after test done");
        rdc <= 1'b1;
        repeat (2) @(posedge clk);
        hm.clr();
        conv(16'h5A3C);
        `CHK("during_word", last, hm.word[15:0])
        `CHK("during_bits", 16, hm.pulses)
        $display("master read during test done");
        ext <= 1'b1;
        repeat (2) @(posedge clk);
        hm.clr();
        nov = 0;
        fork
            conv(16'h0F0F);
            begin
                repeat (2) @(posedge clk);
                hm.sread(4, 16'h0000);
            end
        join
        `CHK("overrun", 1, nov)
        `CHK("prev_bits", 4'h5, hm.word[3:0])
        $display("slave overrun test done");
        cs_n <= 1'b1;
        hm.sread(3, 16'hFFFF);
        cs_n <= 1'b0;
        hm.clr();
        hm.sread(20, 16'hC3A5);
        `CHK("chain_word", {16'h0F0F, 4'hC}, hm.word[19:0])
        $display("slave chain test done");
        results();
    end
endmodule
bind rop_readout rop_checker chk (.*);
